/* logic/lmt_mux_timing.sv */
/*
 Segment LCD core: clock source, frame timing, cascade sync, display RAM
 loading, display register and backplane and segment drive levels.
 Assumes settings arrive from a command decoder after acknowledge and
 display bits arrive one at a time, most significant bit first.
*/
`timescale 1ns/1ps
module lmt_mux_timing (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic osc_in,
	input wire logic osc_ext_sel_in,
	input wire logic clk_pin_in,
	output logic clk_pin_out,
	output logic clk_pin_oe_n_out,
	input wire logic sync_pin_in,
	output logic sync_pin_out,
	output logic sync_pin_oe_n_out,
	input wire logic cfg_wr_in,
	input wire lmt_pkg::lmt_cfg_s cfg_in,
	input wire lmt_pkg::lmt_ptr_s ptr_in,
	input wire lmt_pkg::lmt_dbit_s dbit_in,
	output lmt_pkg::lmt_cfg_s cfg_out,
	output logic osc_enable_out,
	output logic bias_half_out,
	output logic lcd_pol_out,
	output logic [lmt_pkg::SEG_N-1:0] segment_outputs_out,
	output lmt_pkg::lmt_bp_s bp_top_out,
	output lmt_pkg::lmt_bp_s bp_bot_out
);
	import lmt_pkg::*;

	logic rst_meta, rst_n;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Configuration
	lmt_cfg_s cfg, next_cfg;
	logic [1:0] row_last;

	always_comb begin
		next_cfg = cfg_wr_in ? cfg_in : cfg;
		row_last = lmt_row_last(cfg.mode);
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n)
			cfg <= CFG_RST;
		else
			cfg <= next_cfg;
	end

	assign cfg_out = cfg;
	assign bias_half_out = cfg.bias_half;

	// Working clock and clock pin
	logic tick, clk_level;

	lmt_clk_gen u_clk (
		.clk_in(core_clk_in),
		.rst_n_in(rst_n),
		.osc_in(osc_in),
		.ext_sel_in(osc_ext_sel_in),
		.rate_in(cfg.rate),
		.pin_in(clk_pin_in),
		.tick_out(tick),
		.clk_level_out(clk_level),
		.osc_en_out(osc_enable_out)
	);

	assign clk_pin_out = clk_level;
	// Pin turns input in external mode, silent while display is off
	assign clk_pin_oe_n_out = osc_ext_sel_in || !cfg.disp_en;

	// RAM write pointer
	logic [COL_W-1:0] wcol, next_wcol;
	logic [1:0] wrow, next_wrow;
	logic [2:0] bit_cnt, next_bit_cnt;

	always_comb begin
		next_wcol = wcol;
		next_wrow = wrow;
		next_bit_cnt = bit_cnt;
		// A pointer load outranks a bit in the same cycle
		if (ptr_in.load) begin
			next_wcol = (ptr_in.col > COL_LAST) ? '0 : ptr_in.col;
			next_wrow = 2'h0;
			next_bit_cnt = 3'h0;
		end else if (dbit_in.valid) begin
			next_bit_cnt = bit_cnt + 3'h1;
			// Column is done at its last row or at the end of a byte
			if (bit_cnt == 3'h7 || wrow == row_last) begin
				next_wrow = 2'h0;
				next_wcol = (wcol == COL_LAST) ? '0 : wcol + 8'h01;
			end else begin
				next_wrow = wrow + 2'h1;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			wcol <= '0;
			wrow <= 2'h0;
			bit_cnt <= 3'h0;
		end else begin
			wcol <= next_wcol;
			wrow <= next_wrow;
			bit_cnt <= next_bit_cnt;
		end
	end

	// Frame timing and cascade sync
	logic [2:0] ph_cnt, next_ph_cnt;
	logic [1:0] row_idx, next_row_idx;
	logic pol, next_pol;
	logic sync_q;
	logic sync_fall;
	logic rd_en;

	assign sync_pin_out = 1'b0;
	// Open drain, pulled low for the first tick of the first phase of every second frame, the one with pol low
	assign sync_pin_oe_n_out = !(ph_cnt == 3'h0 && row_idx == 2'h0 && !pol);

	always_comb begin
		next_ph_cnt = ph_cnt;
		next_row_idx = row_idx;
		next_pol = pol;
		rd_en = 1'b0;
		// Only a low driven by another device restarts our frame
		sync_fall = sync_q && !sync_pin_in && sync_pin_oe_n_out;
		if (sync_fall) begin
			next_ph_cnt = 3'h0;
			next_row_idx = 2'h0;
			next_pol = 1'b0;
			rd_en = 1'b1;
		end else if (tick) begin
			if (ph_cnt == PH_LAST) begin
				next_ph_cnt = 3'h0;
				rd_en = 1'b1;
				if (row_idx >= row_last) begin
					next_row_idx = 2'h0;
					next_pol = !pol;
				end else begin
					next_row_idx = row_idx + 2'h1;
				end
			end else begin
				next_ph_cnt = ph_cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ph_cnt <= 3'h0;
			row_idx <= 2'h0;
			pol <= 1'b0;
			sync_q <= 1'b1;
		end else begin
			ph_cnt <= next_ph_cnt;
			row_idx <= next_row_idx;
			pol <= next_pol;
			sync_q <= sync_pin_in;
		end
	end

	// Display RAM
	logic [SEG_N-1:0] rd_data;

	lmt_disp_ram u_ram (
		.clk_in(core_clk_in),
		.rst_n_in(rst_n),
		.wr_en_in(dbit_in.valid),
		.wr_col_in(wcol),
		.wr_row_in(wrow),
		.wr_bit_in(dbit_in.value),
		.rd_en_in(rd_en),
		.rd_row_in(next_row_idx),
		.rd_data_out(rd_data)
	);

	// Display register and backplane drive
	function automatic lmt_bp_s bp_map(input logic [1:0] row,
		input lmt_mode_e mode);
		logic [3:0] act;
		logic [3:0] b;
		act = 4'h1 << row;
		unique case (mode)
			// One phase only, so a stale row after a mode switch cannot blank
			LMT_STATIC: b = 4'hf;
			LMT_MUX2: b = {act[1], act[0], act[1], act[0]};
			LMT_MUX3: b = {act[1], act[2], act[1], act[0]};
			LMT_MUX4: b = act;
		endcase
		return lmt_bp_s'(b);
	endfunction

	logic rd_vld, next_rd_vld;
	logic [1:0] pend_row, next_pend_row;
	logic pend_pol, next_pend_pol;
	logic [1:0] shown_row, next_shown_row;
	logic [SEG_N-1:0] disp, next_disp;
	lmt_bp_s bp, next_bp;
	logic next_lcd_pol;

	always_comb begin
		next_rd_vld = rd_en;
		next_pend_row = rd_en ? next_row_idx : pend_row;
		next_pend_pol = rd_en ? next_pol : pend_pol;
		next_shown_row = shown_row;
		next_disp = disp;
		next_bp = bp;
		next_lcd_pol = lcd_pol_out;
		// Update only at a phase edge, so data and backplane move together
		if (rd_vld) begin
			next_shown_row = pend_row;
			next_lcd_pol = pend_pol;
			// One in RAM drives the element on; disabled display is blank
			next_disp = cfg.disp_en ? rd_data : '0;
			next_bp = cfg.disp_en ? bp_map(pend_row, cfg.mode) : '0;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rd_vld <= 1'b0;
			pend_row <= 2'h0;
			pend_pol <= 1'b0;
			shown_row <= 2'h0;
			disp <= '0;
			bp <= '0;
			lcd_pol_out <= 1'b0;
		end else begin
			rd_vld <= next_rd_vld;
			pend_row <= next_pend_row;
			pend_pol <= next_pend_pol;
			shown_row <= next_shown_row;
			disp <= next_disp;
			bp <= next_bp;
			lcd_pol_out <= next_lcd_pol;
		end
	end

	assign segment_outputs_out = disp;
	assign bp_top_out = bp;
	assign bp_bot_out = bp;

	sequence s_fetch;
		rd_en ##1 rd_vld;
	endsequence

	AST_DREG: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		s_fetch |=> shown_row == $past(next_row_idx, 2))
		else $error("display register row does not follow fetch");

	AST_SEG: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		rd_vld && cfg.disp_en |=> segment_outputs_out == $past(rd_data))
		else $error("segments do not show fetched row");

	AST_BP3: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		bp.backplane_out_3 != bp.backplane_out_1 |-> $past(cfg.mode) != LMT_MUX3
		|| !$past(rd_vld))
		else $error("backplane 3 differs from 1 in three-plane mode");

	AST_BP2: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		rd_vld && cfg.mode == LMT_MUX2 |=> bp.backplane_out_2 ==
		bp.backplane_out_0 && bp.backplane_out_3 == bp.backplane_out_1)
		else $error("two-plane duplicates wrong");

	AST_STATIC: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		rd_vld && cfg.mode == LMT_STATIC && cfg.disp_en |=> bp == 4'hf)
		else $error("static backplanes not identical");

	AST_BARS: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		$changed(bp_top_out) |-> bp_top_out == bp_bot_out ##1
		bp_top_out == bp_bot_out)
		else $error("pin bars differ");

	AST_CLKPIN: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		!clk_pin_oe_n_out |-> !osc_ext_sel_in && cfg.disp_en)
		else $error("clock driven out while not allowed");

	AST_SYNC: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		sync_fall |=> ph_cnt == 3'h0 && row_idx == 2'h0 && !pol
		&& rd_vld)
		else $error("sync did not restart frame");

	AST_FRAME: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		tick && !sync_fall && ph_cnt == PH_LAST && row_idx >= row_last
		|=> pol != $past(pol) && row_idx == 2'h0)
		else $error("frame did not wrap");

	AST_BYTE: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		dbit_in.valid && !ptr_in.load && bit_cnt == 3'h7 |=> wrow == 2'h0
		&& wcol == ($past(wcol) == COL_LAST ? 8'h00 : $past(wcol) + 8'h01))
		else $error("byte end column advance wrong");

	AST_FILL: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		dbit_in.valid && !ptr_in.load && bit_cnt != 3'h7 && wrow != row_last
		|=> wrow == $past(wrow) + 2'h1 && wcol == $past(wcol))
		else $error("row fill order wrong");

	AST_RST: assert property (@(posedge core_clk_in)
		$rose(rst_n) |-> cfg == CFG_RST && clk_pin_oe_n_out)
		else $error("reset defaults wrong");
endmodule

/* logic/lmt_pkg.sv */
/*
 Constants, types and helpers shared by the LCD multiplex timing block.
 Assumes one core clock and a command decoder that supplies settings.
*/
package lmt_pkg;
	localparam int SEG_N = 160;
	localparam int ROW_N = 4;
	localparam int OSC_DIV = 64;
	localparam int ACC_W = 12;
	localparam int COL_W = 8;
	localparam logic [COL_W-1:0] COL_LAST = 8'h9f;
	// Working clock ticks per backplane phase, minus one
	localparam logic [2:0] PH_LAST = 3'h7;
	localparam logic [2:0] RATE_NOM = 3'h3;
	localparam logic [6:0] STEP_NOM = 7'(2 ** ACC_W / OSC_DIV);
	localparam logic [6:0] EDGE_NOM = 7'(OSC_DIV - 1);

	typedef enum logic [1:0] {
		LMT_STATIC,
		LMT_MUX2,
		LMT_MUX3,
		LMT_MUX4
	} lmt_mode_e;

	typedef struct packed {
		logic backplane_out_3;
		logic backplane_out_2;
		logic backplane_out_1;
		logic backplane_out_0;
	} lmt_bp_s;

	typedef struct packed {
		lmt_mode_e mode;
		logic bias_half;
		logic disp_en;
		logic [2:0] rate;
	} lmt_cfg_s;

	localparam lmt_cfg_s CFG_RST = '{mode: LMT_MUX4, bias_half: 1'b0,
		disp_en: 1'b0, rate: RATE_NOM};

	typedef struct packed {
		logic load;
		logic [COL_W-1:0] col;
	} lmt_ptr_s;

	typedef struct packed {
		logic valid;
		logic value;
	} lmt_dbit_s;

	// Accumulator step per oscillator edge; 64 means divide by 64
	function automatic logic [6:0] lmt_rate_step(input logic [2:0] rate);
		logic [6:0] s;
		s = STEP_NOM;
		case (rate)
			3'h0: s = 7'h33;
			3'h1: s = 7'h37;
			3'h2: s = 7'h3c;
			3'h3: s = STEP_NOM;
			3'h4: s = 7'h44;
			3'h5: s = 7'h49;
			3'h6: s = 7'h4d;
			default: s = STEP_NOM;
		endcase
		return s;
	endfunction

	// Mode codes equal the number of rows minus one
	function automatic logic [1:0] lmt_row_last(input lmt_mode_e m);
		return 2'(m);
	endfunction
endpackage

/* logic/lmt_clk_gen.sv */
/*
 Working clock tick generator: oscillator divider or external clock pin.
 Assumes osc and pin levels are synchronous to the core clock.
*/
`timescale 1ns/1ps
module lmt_clk_gen (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic osc_in,
	input wire logic ext_sel_in,
	input wire logic [2:0] rate_in,
	input wire logic pin_in,
	output logic tick_out,
	output logic clk_level_out,
	output logic osc_en_out
);
	import lmt_pkg::*;

	logic [ACC_W-1:0] acc, next_acc;
	logic osc_q, pin_q;
	logic [ACC_W:0] sum;
	logic carry;

	always_comb begin
		sum = {1'b0, acc} + {6'h00, lmt_rate_step(rate_in)};
		next_acc = acc;
		carry = 1'b0;
		// Fractional accumulator keeps rate trims at integer steps
		if (!ext_sel_in && osc_in && !osc_q) begin
			next_acc = sum[ACC_W-1:0];
			carry = sum[ACC_W];
		end
		// No edges from the source means the drive stops, DC on the panel
		tick_out = ext_sel_in ? (pin_in && !pin_q) : carry;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acc <= '0;
			osc_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			acc <= next_acc;
			osc_q <= osc_in;
			pin_q <= pin_in;
		end
	end

	assign clk_level_out = acc[ACC_W-1];
	assign osc_en_out = !ext_sel_in;

	logic [6:0] edge_cnt;
	logic nom_run;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			edge_cnt <= '0;
			nom_run <= 1'b0;
		end else begin
			edge_cnt <= tick_out ? 7'h00 : edge_cnt + 7'(osc_in && !osc_q);
			if (ext_sel_in || rate_in != RATE_NOM)
				nom_run <= 1'b0;
			else if (tick_out)
				nom_run <= 1'b1;
		end
	end

	AST_DIV64: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tick_out && !ext_sel_in && rate_in == RATE_NOM && nom_run
		|-> edge_cnt == EDGE_NOM)
		else $error("internal tick spacing is not 64 edges");

	AST_EXT_TICK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ext_sel_in && pin_in && !pin_q |-> tick_out ##1 acc == $past(acc))
		else $error("external clock edge not used directly");
endmodule

/* logic/lmt_disp_ram.sv */
/*
 Display RAM, 160 columns by 4 rows, bit writes and registered row reads.
 Assumes write column never exceeds the last column.
*/
`timescale 1ns/1ps
module lmt_disp_ram (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic wr_en_in,
	input wire logic [lmt_pkg::COL_W-1:0] wr_col_in,
	input wire logic [1:0] wr_row_in,
	input wire logic wr_bit_in,
	input wire logic rd_en_in,
	input wire logic [1:0] rd_row_in,
	output logic [lmt_pkg::SEG_N-1:0] rd_data_out
);
	import lmt_pkg::*;

	logic [SEG_N-1:0] mem [ROW_N];
	logic [SEG_N-1:0] next_rd;

	// Static array, contents are not cleared by reset
	for (genvar r = 0; r < ROW_N; r++) begin : g_row
		always_ff @(posedge clk_in) begin
			if (wr_en_in && wr_row_in == 2'(r))
				mem[r][wr_col_in] <= wr_bit_in;
		end
	end

	always_comb begin
		next_rd = rd_en_in ? mem[rd_row_in] : rd_data_out;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			rd_data_out <= '0;
		else
			rd_data_out <= next_rd;
	end

	AST_RAM_WR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_en_in |=> mem[$past(wr_row_in)][$past(wr_col_in)] == $past(wr_bit_in))
		else $error("display bit not stored on arrival");
endmodule

/* test/lmt_panel_model.sv */
/*
 Panel model: keeps the last segment pattern seen in each backplane row.
 Assumes registered drive levels that change only after a core clock edge.
*/
`timescale 1ns/1ps
module lmt_panel_model
	import lmt_pkg::*;
(
	input wire logic clk_in,
	input wire logic chk_en_in,
	input wire lmt_pkg::lmt_mode_e mode_in,
	input wire logic [lmt_pkg::SEG_N-1:0] seg_in,
	input wire lmt_pkg::lmt_bp_s top_in,
	input wire lmt_pkg::lmt_bp_s bot_in,
	output logic [3:0][lmt_pkg::SEG_N-1:0] rows_out,
	output int err_out
);
	int row;

	// Backplanes active in a row, per drive mode
	function automatic logic [3:0] bp_pat(input lmt_mode_e m, input int r);
		case (m)
			LMT_STATIC: return 4'hf;
			LMT_MUX2: return r[0] ? 4'ha : 4'h5;
			LMT_MUX3: return r == 1 ? 4'ha : 4'(1 << r);
			default: return 4'(1 << r);
		endcase
	endfunction

	initial begin
		rows_out = '0;
		err_out = 0;
	end

	// Sampled half a cycle after the drive edge, when levels are settled
	always @(negedge clk_in) begin
		row = 0;
		for (int i = 3; i >= 0; i--) begin
			if (top_in[i] === 1'b1) row = i;
		end
		if (top_in !== bot_in) err_out++;
		if (top_in !== 4'h0) begin
			rows_out[row] = seg_in;
			if (chk_en_in && top_in !== bp_pat(mode_in, row))
				err_out++;
		end
	end
endmodule

/* test/lmt_mux_timing_tb_top.sv */
/*
 Self-checking bench for the LCD multiplex timing core with a panel model.
 Assumes the panel model and the shared package are compiled first.
*/
`timescale 1ns/1ps
module lmt_mux_timing_tb_top;
	import lmt_pkg::*;
	logic core_clk_in, nrst_in, osc_in, osc_ext_sel_in, clk_pin_in;
	logic clk_pin_out, clk_pin_oe_n_out, sync_pin_in, sync_pin_out;
	logic sync_pin_oe_n_out, cfg_wr_in, osc_enable_out, bias_half_out;
	logic lcd_pol_out, sync_pull_n, chk_en;
	lmt_cfg_s cfg_in, cfg_out;
	lmt_ptr_s ptr_in;
	lmt_dbit_s dbit_in;
	logic [SEG_N-1:0] segment_outputs_out;
	lmt_bp_s bp_top_out, bp_bot_out;
	logic [3:0][SEG_N-1:0] rows;
	lmt_mode_e cur_mode;
	logic [3:0] mdl [SEG_N];
	int panel_err, err_count, comparisons, wcol, wrow;
	int steps [8] = '{51, 55, 60, 64, 68, 73, 77, 64};

	// Open drain wire with pull-up
	assign sync_pin_in = sync_pull_n & (sync_pin_oe_n_out | sync_pin_out);

	lmt_mux_timing dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
		.osc_in(osc_in), .osc_ext_sel_in(osc_ext_sel_in),
		.clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out),
		.clk_pin_oe_n_out(clk_pin_oe_n_out), .sync_pin_in(sync_pin_in),
		.sync_pin_out(sync_pin_out), .sync_pin_oe_n_out(sync_pin_oe_n_out),
		.cfg_wr_in(cfg_wr_in), .cfg_in(cfg_in), .ptr_in(ptr_in),
		.dbit_in(dbit_in), .cfg_out(cfg_out),
		.osc_enable_out(osc_enable_out), .bias_half_out(bias_half_out),
		.lcd_pol_out(lcd_pol_out),
		.segment_outputs_out(segment_outputs_out),
		.bp_top_out(bp_top_out), .bp_bot_out(bp_bot_out));

	lmt_panel_model panel (.clk_in(core_clk_in), .chk_en_in(chk_en),
		.mode_in(cur_mode), .seg_in(segment_outputs_out),
		.top_in(bp_top_out), .bot_in(bp_bot_out), .rows_out(rows),
		.err_out(panel_err));

	initial begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end

	// Both clock sources never stop, so the panel never sits at DC
	always @(negedge core_clk_in) begin
		osc_in <= ~osc_in;
		clk_pin_in <= ~clk_pin_in;
	end

	task automatic chk(input logic [SEG_N-1:0] got,
		input logic [SEG_N-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic set_cfg(input lmt_mode_e m, input logic en, input logic ext,
		input logic [2:0] rate);
		lmt_cfg_s c;
		c = '{mode: m, bias_half: m == LMT_MUX2, disp_en: en, rate: rate};
		@(negedge core_clk_in);
		osc_ext_sel_in = ext;
		cfg_in = c;
		cfg_wr_in = 1'b1;
		@(negedge core_clk_in);
		cfg_wr_in = 1'b0;
		chk(SEG_N'(cfg_out), SEG_N'(c));
		chk(SEG_N'(bias_half_out), SEG_N'(c.bias_half));
		chk(SEG_N'(clk_pin_oe_n_out), SEG_N'(ext | !en));
		chk(SEG_N'(osc_enable_out), SEG_N'(!ext));
	endtask

	task automatic load_ptr(input logic [7:0] c);
		@(negedge core_clk_in);
		ptr_in = '{load: 1'b1, col: c};
		wcol = c > 8'h9f ? 0 : int'(c);
		wrow = 0;
		@(negedge core_clk_in);
		ptr_in = '0;
	endtask

	// Bits kept high back to back; one clear at the end only
	task automatic send(input int n, input logic rnd);
		logic [7:0] b;
		for (int k = 0; k < n; k++) begin
			b = rnd ? 8'($urandom) : 8'h00;
			for (int i = 7; i >= 0; i--) begin
				dbit_in = '{valid: 1'b1, value: b[i]};
				mdl[wcol][wrow] = b[i];
				wrow++;
				if (wrow > int'(cur_mode)) begin
					wrow = 0;
					wcol = (wcol + 1) % SEG_N;
				end
				@(negedge core_clk_in);
			end
			if (wrow != 0) begin
				wrow = 0;
				wcol = (wcol + 1) % SEG_N;
			end
		end
		dbit_in = '0;
	endtask

	task automatic show_chk();
		logic [SEG_N-1:0] e;
		repeat (40) @(negedge core_clk_in);
		chk_en = 1'b1;
		repeat (160) @(negedge core_clk_in);
		for (int r = 0; r <= int'(cur_mode); r++) begin
			for (int c = 0; c < SEG_N; c++) e[c] = mdl[c][r];
			chk(rows[r], e);
		end
		chk(SEG_N'(panel_err), '0);
		chk_en = 1'b0;
	endtask

	// Cycles from one working clock rise to the n-th after it
	task automatic osc_chk(input logic [2:0] rate, input int n);
		int cyc, rises, g;
		logic prev;
		set_cfg(LMT_MUX4, 1'b1, 1'b0, rate);
		cyc = 0;
		rises = 0;
		prev = clk_pin_out;
		for (g = 0; g < 20000 && rises <= n; g++) begin
			@(negedge core_clk_in);
			cyc++;
			if (clk_pin_out === 1'b1 && prev === 1'b0) begin
				if (rises == 0) cyc = 0;
				rises++;
			end
			prev = clk_pin_out;
		end
		chk(SEG_N'(cyc), SEG_N'(2 * 4096 * n / steps[rate]));
	endtask

	initial begin
		nrst_in = 1'b0;
		osc_in = 1'b0;
		clk_pin_in = 1'b0;
		osc_ext_sel_in = 1'b1;
		sync_pull_n = 1'b1;
		cfg_wr_in = 1'b0;
		cfg_in = CFG_RST;
		ptr_in = '0;
		dbit_in = '0;
		chk_en = 1'b0;
		err_count = 0;
		comparisons = 0;
		cur_mode = LMT_MUX4;
		for (int c = 0; c < SEG_N; c++) mdl[c] = 4'h0;
		void'($urandom(32'he869_cd2e));
		repeat (12) @(negedge core_clk_in);
		chk(SEG_N'(cfg_out), SEG_N'(CFG_RST));
		chk(SEG_N'(clk_pin_oe_n_out), SEG_N'(1'b1));
		chk(segment_outputs_out, '0);
		chk(SEG_N'(bp_top_out), '0);
		nrst_in = 1'b1;
		repeat (3) @(negedge core_clk_in);
		set_cfg(LMT_MUX4, 1'b1, 1'b1, RATE_NOM);
		load_ptr(8'h00);
		send(80, 1'b0);
		for (int m = 0; m < 4; m++) begin
			cur_mode = lmt_mode_e'(m);
			set_cfg(cur_mode, 1'b1, 1'b1, RATE_NOM);
			load_ptr(m == 3 ? 8'h9c : 8'($urandom_range(150)));
			send(6, 1'b1);
			show_chk();
		end
		// Pointer beyond the last column starts at column 0
		load_ptr(8'hc8);
		send(1, 1'b1);
		show_chk();
		for (int g = 0; g < 200 && bp_top_out.backplane_out_2 !== 1'b1; g++) begin
			@(negedge core_clk_in);
		end
		sync_pull_n = 1'b0;
		@(negedge core_clk_in);
		sync_pull_n = 1'b1;
		chk(SEG_N'(sync_pin_oe_n_out), '0);
		chk(SEG_N'(sync_pin_out), '0);
		repeat (4) @(negedge core_clk_in);
		chk(SEG_N'(bp_top_out), SEG_N'(4'h1));
		chk(SEG_N'(lcd_pol_out), '0);
		set_cfg(LMT_MUX4, 1'b0, 1'b0, RATE_NOM);
		// Blanking waits for the next phase edge, up to eight slow ticks
		repeat (1100) @(negedge core_clk_in);
		chk(segment_outputs_out, '0);
		chk(SEG_N'(bp_top_out), '0);
		osc_chk(RATE_NOM, 1);
		osc_chk(3'h0, 51);
		summarize();
	end

	// Whole run needs a little under two fifths of this span
	initial begin
		#1_500_000;
		err_count++;
		summarize();
	end
endmodule
